// *** src/video_capture_map.vh ***
// Constants of the video capture path: field modes, ratios, conversion factors and memory geometry.
`ifndef VIDEO_CAPTURE_MAP_VH
`define VIDEO_CAPTURE_MAP_VH
`define FIELD_MODE_PROG       2'b00
`define FIELD_MODE_COMPOSITE  2'b01
`define FIELD_MODE_ODD        2'b10
`define FIELD_MODE_EVEN       2'b11
`define RATIO_FULL            2'b00
`define RATIO_HALF            2'b01
`define RATIO_THIRD           2'b10
`define RATIO_QUARTER         2'b11
`define RATIO_H_LSB           0
`define RATIO_V_LSB           2
`define RATIO_BYPASS_BIT      4
`define CHROMA_ZERO           10'sh080
`define COEF_R_CR             12'sh0AF
`define COEF_G_CR             12'sh059
`define COEF_G_CB             12'sh005
`define COEF_B_CB             12'sh0DD
`define COEF_SHIFT            7
`define LINE_PITCH_512        13'h0200
`define LINE_PITCH_1024       13'h0400
`define AREA_COUNT            2'h3
`endif

// *** src/video_capture_scale_convert.v ***
// Video capture path: field selection, reduction, addressing and YCbCr to RGB conversion.
// Summary of operation
// - Field mode 11 stores only even fields, parity input high.
// - Non-interlaced source in even-only mode skips every second field.
// - First field select puts first field on upper or lower line.
// - Five-bit ratio field reduces by 1/2, 1/3 or 1/4 per axis.
// - Capture area is written as 16-bit pixels.
// - Sample bit 7 arrives on the highest video pin.
// - Chroma is offset binary around 128; luma spans 16 to 235.
// - Red, green and blue follow the fixed conversion factors.
// - Conversion yields 16-bit RGB pixels.
// - Store-time bit converts before write; else YCbCr is stored.
// - Data sampled at rising pixel clock edge; syncs sampled on every core clock.
// - Setting capture enable restarts at area zero, then rotates.
`timescale 1ns/1ps
`include "video_capture_map.vh"
module video_capture_scale_convert (
    input  wire        core_clk,
    input  wire        reset,
    input  wire        pixel_clock_in,
    input  wire [7:0]  pixel_in,
    input  wire        hsync_n_in,
    input  wire        vsync_n_in,
    input  wire        field_parity_in,
    input  wire        capture_enable,
    input  wire        field_mode_hi,
    input  wire        field_mode_lo,
    input  wire        first_field_select,
    input  wire [4:0]  reduction_ratio_field,
    input  wire        store_time_convert,
    input  wire        memory_width_select,
    input  wire [9:0]  window_width,
    input  wire [9:0]  window_height,
    input  wire [12:0] start_y0,
    input  wire [10:0] start_x0,
    input  wire [12:0] start_y1,
    input  wire [10:0] start_x1,
    input  wire [12:0] start_y2,
    input  wire [10:0] start_x2,
    output reg         mem_write,
    output reg  [23:0] mem_address,
    output reg  [15:0] mem_data,
    output reg  [1:0]  area_done,
    output reg         capture_busy
);
    // Two-stage synchronisers for every pin from the decoder side.
    reg [7:0] data_s1;
    reg [7:0] data_s2;
    reg [3:0] ctl_s1;
    reg [3:0] ctl_s2;
    reg       clk_prev;
    always @(posedge core_clk) begin
        if (reset) begin
            data_s1  <= 8'h00;
            data_s2  <= 8'h00;
            // Idle pin levels: pixel clock low, syncs high, so no false edge follows reset.
            ctl_s1   <= 4'b0110;
            ctl_s2   <= 4'b0110;
            clk_prev <= 1'b0;
        end else begin
            data_s1  <= pixel_in;
            data_s2  <= data_s1;
            ctl_s1   <= {pixel_clock_in, hsync_n_in, vsync_n_in, field_parity_in};
            ctl_s2   <= ctl_s1;
            clk_prev <= ctl_s2[3];
        end
    end
    wire       pclk_rise = ctl_s2[3] & ~clk_prev;
    wire       hs_n      = ctl_s2[2];
    wire       vs_n      = ctl_s2[1];
    wire       parity    = ctl_s2[0];
    wire [1:0] field_mode = {field_mode_hi, field_mode_lo};
    wire [1:0] ratio_h   = reduction_ratio_field[`RATIO_H_LSB+1:`RATIO_H_LSB];
    wire [1:0] ratio_v   = reduction_ratio_field[`RATIO_V_LSB+1:`RATIO_V_LSB];
    wire       ratio_on  = ~reduction_ratio_field[`RATIO_BYPASS_BIT];

    // Sync edges are taken on the sampled levels.
    reg hs_prev;
    reg vs_prev;
    reg en_prev;
    always @(posedge core_clk) begin
        if (reset) begin
            hs_prev <= 1'b1;
            vs_prev <= 1'b1;
            en_prev <= 1'b0;
        end else begin
            hs_prev <= hs_n;
            vs_prev <= vs_n;
            en_prev <= capture_enable;
        end
    end
    wire hs_start = hs_prev & ~hs_n;
    wire vs_start = vs_prev & ~vs_n;
    wire en_rise  = capture_enable & ~en_prev;

    // Field bookkeeping.
    localparam ST_IDLE  = 2'd0;
    localparam ST_WAITV = 2'd1;
    localparam ST_WAITH = 2'd2;
    localparam ST_RUN   = 2'd3;
    reg [1:0]  state;
    reg [1:0]  area;
    reg        field_keep;
    reg        field_toggle;
    reg        parity_last;
    reg        have_parity;
    reg        next_field_keep;
    reg        second_field;
    reg [9:0]  line;
    reg [1:0]  vphase;
    reg [1:0]  hphase;
    reg [9:0]  column;
    reg [1:0]  byte_phase;
    reg [7:0]  cb;
    reg [7:0]  cr;
    reg [7:0]  luma;
    reg        pix_strobe;
    wire [1:0] max_h = ratio_on ? ratio_h : `RATIO_FULL;
    wire [1:0] max_v = ratio_on ? ratio_v : `RATIO_FULL;
    // Even-only keeps parity high; odd-only parity low; on a non-interlaced source
    // the parity never changes, so every second field is dropped instead.
    wire       even_sel   = (field_mode == `FIELD_MODE_EVEN);
    wire       single_fld = field_mode[1];
    // The first field after enable is always judged by its parity; later, a parity
    // that did not alternate marks a non-interlaced source.
    always @* begin
        if (!single_fld) begin
            next_field_keep = 1'b1;
        end else if (!have_parity || parity != parity_last) begin
            next_field_keep = (parity == even_sel);
        end else begin
            next_field_keep = ~field_toggle;
        end
    end
    wire       line_kept  = (vphase == 2'd0);
    wire       composite  = (field_mode == `FIELD_MODE_COMPOSITE);
    // First field goes to the upper line unless first field select is set.
    wire       lower_line = composite & (second_field ^ first_field_select);
    wire [9:0] mem_line   = composite ? {line[8:0], lower_line} : line;
    reg  [12:0] sy;
    reg  [10:0] sx;
    // Origin of the area that is being filled.
    always @* begin
        if (area == 2'd0) begin
            sy = start_y0;
            sx = start_x0;
        end else if (area == 2'd1) begin
            sy = start_y1;
            sx = start_x1;
        end else begin
            sy = start_y2;
            sx = start_x2;
        end
    end
    wire [12:0] pitch = memory_width_select ? `LINE_PITCH_1024 : `LINE_PITCH_512;
    wire [23:0] row_y = {11'h000, sy} + {14'h0000, mem_line};
    wire [23:0] next_address = row_y * {11'h000, pitch} + {13'h0000, sx} + {14'h0000, column};

    always @(posedge core_clk) begin
        if (reset) begin
            state        <= ST_IDLE;
            area         <= 2'd0;
            field_keep   <= 1'b0;
            parity_last  <= 1'b0;
            have_parity  <= 1'b0;
            field_toggle <= 1'b0;
            second_field <= 1'b0;
            line         <= 10'h000;
            vphase       <= 2'd0;
            hphase       <= 2'd0;
            column       <= 10'h000;
            byte_phase   <= 2'd0;
            cb           <= 8'h80;
            cr           <= 8'h80;
            luma         <= 8'h10;
            pix_strobe   <= 1'b0;
            area_done    <= 2'd0;
            capture_busy <= 1'b0;
        end else begin
            pix_strobe <= 1'b0;
            if (!capture_enable) begin
                state        <= ST_IDLE;
                capture_busy <= 1'b0;
            end else if (en_rise) begin
                state        <= ST_WAITV;
                area         <= 2'd0;
                second_field <= 1'b0;
                field_toggle <= 1'b0;
                have_parity  <= 1'b0;
                capture_busy <= 1'b1;
            end else begin
                case (state)
                    ST_IDLE: begin
                        state <= ST_IDLE;
                    end
                    default: begin
                        if (vs_start) begin
                            // Field end: rotate areas once a frame is complete.
                            if (state == ST_RUN && field_keep && (!composite || second_field)) begin
                                area_done <= area;
                                area      <= (area == `AREA_COUNT - 2'd1) ? 2'd0 : area + 2'd1;
                            end
                            if (state == ST_RUN && field_keep && composite)
                                second_field <= ~second_field;
                            field_toggle <= ~field_toggle;
                            // Interlaced source uses parity, otherwise alternate fields.
                            field_keep  <= next_field_keep;
                            parity_last <= parity;
                            have_parity <= 1'b1;
                            line   <= 10'h000;
                            vphase <= 2'd0;
                            state  <= ST_WAITH;
                        end else if (hs_start && state != ST_WAITV) begin
                            // Drop lines according to the vertical ratio.
                            // The first line of a field is always kept.
                            if (state == ST_RUN) begin
                                if (line_kept)
                                    line <= line + 10'h001;
                                vphase <= (vphase == max_v) ? 2'd0 : vphase + 2'd1;
                            end
                            hphase     <= 2'd0;
                            column     <= 10'h000;
                            byte_phase <= 2'd0;
                            state      <= ST_RUN;
                        end else if (state == ST_RUN && pclk_rise && hs_n) begin
                            // Byte order Cb, Y, Cr, Y with bit 7 on the top pin.
                            byte_phase <= byte_phase + 2'd1;
                            case (byte_phase)
                                2'd0: cb <= data_s2;
                                2'd2: cr <= data_s2;
                                default: begin
                                    luma   <= data_s2;
                                    hphase <= (hphase == max_h) ? 2'd0 : hphase + 2'd1;
                                    if (hphase == 2'd0 && line_kept && field_keep &&
                                        column < window_width && line < window_height)
                                        pix_strobe <= 1'b1;
                                end
                            endcase
                        end
                        if (pix_strobe)
                            column <= column + 10'h001;
                    end
                endcase
            end
        end
    end

    // Conversion in signed fixed point, factors scaled by 128.
    wire signed [10:0] ys  = {3'b000, luma};
    wire signed [10:0] crs = {3'b000, cr} - `CHROMA_ZERO;
    wire signed [10:0] cbs = {3'b000, cb} - `CHROMA_ZERO;
    wire signed [22:0] r_prod = crs * `COEF_R_CR;
    wire signed [22:0] g_prod = crs * `COEF_G_CR + cbs * `COEF_G_CB;
    wire signed [22:0] b_prod = cbs * `COEF_B_CB;
    wire signed [12:0] r_raw = ys + r_prod[19:`COEF_SHIFT];
    wire signed [12:0] g_raw = ys - g_prod[19:`COEF_SHIFT];
    wire signed [12:0] b_raw = ys + b_prod[19:`COEF_SHIFT];
    function [7:0] clip;
        input signed [12:0] v;
        begin
            clip = (v < 0) ? 8'h00 : (v > 13'sd255) ? 8'hff : v[7:0];
        end
    endfunction
    wire [7:0] r8 = clip(r_raw);
    wire [7:0] g8 = clip(g_raw);
    wire [7:0] b8 = clip(b_raw);
    // 5-6-5 RGB word, or Y with the alternating chroma when stored raw.
    wire [15:0] rgb565 = {r8[7:3], g8[7:2], b8[7:3]};
    wire [15:0] ycc    = {luma, column[0] ? cr : cb};

    always @(posedge core_clk) begin
        if (reset) begin
            mem_write   <= 1'b0;
            mem_address <= 24'h00_0000;
            mem_data    <= 16'h0000;
        end else begin
            mem_write <= pix_strobe;
            if (pix_strobe) begin
                mem_address <= next_address;
                mem_data    <= store_time_convert ? rgb565 : ycc;
            end
        end
    end
endmodule

// *** verif/video_capture_scale_convert_properties.sv ***
// Port-level checks of the video capture path.
`timescale 1ns/1ps
module video_capture_scale_convert_properties (
    input wire        core_clk,
    input wire        reset,
    input wire        pixel_clock_in,
    input wire        field_parity_in,
    input wire        field_mode_hi,
    input wire        field_mode_lo,
    input wire [4:0]  reduction_ratio_field,
    input wire        mem_write,
    input wire [23:0] mem_address,
    input wire [15:0] mem_data,
    input wire        capture_busy
);
    logic [7:0] since_rise;
    logic [7:0] since_write;
    wire        h_reduced = reduction_ratio_field[1:0] != 2'b00 && !reduction_ratio_field[4];
    always @(posedge core_clk) begin
        since_rise  <= reset ? 8'hff : ($rose(pixel_clock_in) ? 8'h00 : since_rise + {7'h00, ~&since_rise});
        since_write <= (reset || mem_write) ? (reset ? 8'hff : 8'h00) : since_write + {7'h00, ~&since_write};
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    chk_reset_quiet: assert property (disable iff (1'b0) reset |=> !mem_write && !capture_busy)
        else $error("write or busy right after reset");
    chk_write_pulse: assert property (mem_write |=> !mem_write) else $error("write longer than one cycle");
    chk_pclk_timing: assert property (mem_write |-> since_rise inside {[2:7]})
        else $error("write not tied to a pixel clock rise");
    chk_addr_step: assert property (mem_write ##16 mem_write |-> mem_address == $past(mem_address, 16) + 24'h00_0001)
        else $error("address did not step by one pixel");
    chk_output_hold: assert property (!mem_write |-> $stable(mem_address) && $stable(mem_data))
        else $error("address or data moved without a write");
    chk_busy_write: assert property (mem_write |-> capture_busy) else $error("write while not busy");
    chk_field_refused: assert property ((field_mode_hi && field_mode_lo != field_parity_in) [*8] |-> !mem_write)
        else $error("write during an unwanted field");
    chk_reduce_gap: assert property (mem_write && h_reduced |-> since_write >= 8'h18)
        else $error("reduced line written at full rate");
endmodule
bind video_capture_scale_convert video_capture_scale_convert_properties i_video_capture_scale_convert_properties (
    .core_clk(core_clk), .reset(reset), .pixel_clock_in(pixel_clock_in), .field_parity_in(field_parity_in),
    .field_mode_hi(field_mode_hi), .field_mode_lo(field_mode_lo), .reduction_ratio_field(reduction_ratio_field),
    .mem_write(mem_write), .mem_address(mem_address), .mem_data(mem_data), .capture_busy(capture_busy));

// *** verif/video_decoder_model.sv ***
// Behavioural decoder sending syncs, field parity and a Cb Y Cr Y byte stream.
`timescale 1ns/1ps
module video_decoder_model (
    output logic       pixel_clock_in = 1'b0,
    output logic [7:0] pixel_in = 8'h00,
    output logic       hsync_n_in = 1'b1,
    output logic       vsync_n_in = 1'b1,
    output logic       field_parity_in = 1'b0
);
    logic [7:0] line_bytes [0:31];
    task automatic send_field(input logic parity, input int lines, input int nbytes);
        #3.3 field_parity_in = parity;
        #200 vsync_n_in = 1'b0;
        #400 vsync_n_in = 1'b1;
        for (int l = 0; l < lines; l++) begin
            #300 hsync_n_in = 1'b0;
            #300 hsync_n_in = 1'b1;
            for (int b = 0; b < nbytes; b++) begin
                pixel_in = line_bytes[l * nbytes + b];
                #40 pixel_clock_in = 1'b1;
                #40 pixel_clock_in = 1'b0;
            end
            pixel_in = ~pixel_in;
        end
    endtask
endmodule

// *** verif/video_capture_scale_convert_bench.sv ***
// Self-checking bench for the video capture path.
`timescale 1ns/1ps
`include "video_capture_map.vh"
module video_capture_scale_convert_bench;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        capture_enable = 1'b0;
    logic [1:0]  mode = 2'b00;
    logic        first_field_select = 1'b0;
    logic [4:0]  reduction_ratio_field = 5'h00;
    logic        store_time_convert = 1'b0;
    logic        memory_width_select = 1'b0;
    logic [9:0]  window_width = 10'h008;
    logic [12:0] start_y = 13'h0000;
    logic [10:0] start_x = 11'h000;
    logic [31:0] rng = 32'h0000_64BF;
    int          failures = 0;
    int          checked = 0;
    logic [23:0] got_addr [$];
    logic [15:0] got_data [$];
    wire         pixel_clock_in;
    wire  [7:0]  pixel_in;
    wire         hsync_n_in;
    wire         vsync_n_in;
    wire         field_parity_in;
    wire         mem_write;
    wire  [23:0] mem_address;
    wire  [15:0] mem_data;
    wire  [1:0]  area_done;
    wire         capture_busy;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (mem_write === 1'b1) begin
            got_addr.push_back(mem_address);
            got_data.push_back(mem_data);
        end
    end
    video_decoder_model i_video_decoder_model (.pixel_clock_in(pixel_clock_in), .pixel_in(pixel_in),
        .hsync_n_in(hsync_n_in), .vsync_n_in(vsync_n_in), .field_parity_in(field_parity_in));
    video_capture_scale_convert i_video_capture_scale_convert (.core_clk(core_clk), .reset(reset),
        .pixel_clock_in(pixel_clock_in), .pixel_in(pixel_in), .hsync_n_in(hsync_n_in), .vsync_n_in(vsync_n_in),
        .field_parity_in(field_parity_in), .capture_enable(capture_enable), .field_mode_hi(mode[1]),
        .field_mode_lo(mode[0]), .first_field_select(first_field_select), .reduction_ratio_field(reduction_ratio_field),
        .store_time_convert(store_time_convert), .memory_width_select(memory_width_select),
        .window_width(window_width), .window_height(10'h002), .start_y0(start_y), .start_x0(start_x),
        .start_y1(start_y + 13'h0010), .start_x1(start_x), .start_y2(start_y + 13'h0020), .start_x2(start_x),
        .mem_write(mem_write), .mem_address(mem_address), .mem_data(mem_data), .area_done(area_done),
        .capture_busy(capture_busy));
    function automatic logic [31:0] xorshift();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    function automatic int kept_count(input int n, input logic [1:0] ratio);
        return (n + ratio) / (ratio + 1);
    endfunction
    function automatic logic [15:0] exp_pixel(input int y, input int c, input int cb, input int cr, input logic rgb);
        int r;
        int g;
        int b;
        r = y + (((cr - `CHROMA_ZERO) * `COEF_R_CR) >>> `COEF_SHIFT);
        g = y - (((cr - `CHROMA_ZERO) * `COEF_G_CR + (cb - `CHROMA_ZERO) * `COEF_G_CB) >>> `COEF_SHIFT);
        b = y + (((cb - `CHROMA_ZERO) * `COEF_B_CB) >>> `COEF_SHIFT);
        r = (r < 0) ? 0 : (r > 255) ? 255 : r;
        g = (g < 0) ? 0 : (g > 255) ? 255 : g;
        b = (b < 0) ? 0 : (b > 255) ? 255 : b;
        return rgb ? {r[7:3], g[7:2], b[7:3]} : {y[7:0], c[7:0]};
    endfunction
    task automatic compare(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        close_out();
    end
    initial begin
        logic [31:0] r;
        logic [7:0]  byte_val;
        logic [7:0]  cb_iter;
        logic [7:0]  cr_fixed;
        int          area_idx;
        logic [1:0]  rh;
        logic [1:0]  rv;
        int          cols;
        int          total;
        int          line;
        int          idx;
        repeat (4) @(posedge core_clk);
        #1 reset = 1'b0;
        // Cr stays the same all run, so the Cr held over from an earlier pair is known.
        cr_fixed = 8'(16 + (xorshift() % 225));
        for (int it = 0; it < 12; it++) begin
            r = xorshift();
            if (it == 0) r[2:0] = 3'b011;
            if (it == 1) r[7:3] = 5'h1F;
            mode = r[1:0];
            reduction_ratio_field = r[7:3];
            first_field_select = r[8];
            window_width = {7'h00, r[10:9], 1'b0} + 10'h002;
            store_time_convert = r[11];
            memory_width_select = r[12];
            start_y = {2'b00, r[19:13], 4'h0};
            cb_iter = 8'(16 + (xorshift() % 225));
            start_x = {2'b00, r[23:21], 6'h00};
            for (int k = 0; k < 32; k++) begin
                byte_val = 8'(16 + (xorshift() % 220));
                i_video_decoder_model.line_bytes[k] = k[0] ? byte_val : (k[1] ? cr_fixed : cb_iter);
            end
            @(posedge core_clk);
            #1 capture_enable = 1'b1;
            got_addr.delete();
            got_data.delete();
            i_video_decoder_model.send_field(r[2], 2, 16);
            repeat (20) @(posedge core_clk);
            #1 compare({23'h00_0000, capture_busy}, 24'h00_0001);
            capture_enable = 1'b0;
            rh = r[7] ? 2'b00 : r[4:3];
            rv = r[7] ? 2'b00 : r[6:5];
            cols = kept_count(8, rh);
            if (cols > window_width) cols = window_width;
            total = (!r[1] || r[0] == r[2]) ? cols * kept_count(2, rv) : 0;
            compare(24'(got_addr.size()), 24'(total));
            for (int i = 0; i < total && i < got_addr.size(); i++) begin
                line = (r[1:0] == 2'b01) ? 2 * (i / cols) + r[8] : i / cols;
                idx = (i / cols) * 16 + 2 * (i % cols);
                compare(got_addr[i], 24'((start_y + line) * (r[12] ? `LINE_PITCH_1024 : `LINE_PITCH_512)
                    + start_x + i % cols));
                if (rh == 2'b00 && rv == 2'b00)
                    compare({8'h00, got_data[i]}, {8'h00, exp_pixel(i_video_decoder_model.line_bytes[idx + 1],
                        i_video_decoder_model.line_bytes[idx], cb_iter, cr_fixed, r[11])});
            end
        end
        // Area rotation, restart at area zero, and alternate fields of a non-interlaced source.
        window_width = 10'h008;
        reduction_ratio_field = 5'h00;
        for (int m = 0; m < 2; m++) begin
            mode = m ? 2'b11 : 2'b00;
            @(posedge core_clk);
            #1 capture_enable = 1'b1;
            for (int f = 0; f < 4; f++) begin
                if (f == 3) begin
                    capture_enable = 1'b0;
                    @(posedge core_clk);
                    #1 capture_enable = 1'b1;
                end
                got_addr.delete();
                got_data.delete();
                i_video_decoder_model.send_field(1'b1, 2, 16);
                repeat (20) @(posedge core_clk);
                #1 area_idx = (f == 3) ? 0 : (m ? f / 2 : f);
                compare(24'(got_addr.size()), (m && f == 1) ? 24'h00_0000 : 24'h00_0010);
                if (got_addr.size() > 0)
                    compare(got_addr[0], 24'((start_y + 16 * area_idx) *
                        (memory_width_select ? `LINE_PITCH_1024 : `LINE_PITCH_512) + start_x));
                if (f == 2)
                    compare({22'h00_0000, area_done}, m ? 24'h00_0000 : 24'h00_0001);
            end
            capture_enable = 1'b0;
        end
        close_out();
    end
endmodule
